// *** src/pdio_pkg.sv ***
/*
 Package for the digital I/O block of the power controller: APB register
 offsets, field positions, reset values, timing counts and carrier types.
 Assumes a 200 MHz pclk and 32-bit APB data.
*/
package pdio_pkg;
   // Clock rate
   localparam int unsigned CLK_MHZ = 200;
   // Register byte offsets
   localparam logic [7:0] PDIO_CFG_ADDR    = 8'h00;
   localparam logic [7:0] PDIO_MASK_ADDR   = 8'h04;
   localparam logic [7:0] PDIO_FLAG_ADDR   = 8'h08;
   localparam logic [7:0] PDIO_STATUS_ADDR = 8'h0c;
   localparam logic [7:0] PDIO_CMD_ADDR    = 8'h10;
   // Config fields
   localparam int CFG_SWITCH_STYLE = 0;
   localparam int CFG_DIR          = 1;
   localparam int CFG_DRIVE_STYLE  = 2;
   localparam int CFG_FILTER_ON    = 3;
   localparam int CFG_OUT_LEVEL    = 4;
   localparam logic [4:0] CFG_RESET = 5'h02;
   // Flag / mask fields
   localparam int IRQ_PIN_RISE = 0;
   localparam int IRQ_PIN_FALL = 1;
   localparam int IRQ_KEY_FALL = 2;
   localparam int IRQ_KEY_RISE = 3;
   localparam int IRQ_BITS     = 4;
   localparam logic [3:0] MASK_RESET = 4'hf;
   // Status fields
   localparam int ST_PIN_LEVEL = 0;
   localparam int ST_KEY_LEVEL = 1;
   localparam int ST_ON        = 2;
   localparam int ST_HOLD      = 3;
   localparam int ST_STATE_LSB = 4;
   // Soft power command encodings
   localparam logic [1:0] CMD_NONE   = 2'h0;
   localparam logic [1:0] CMD_OFF    = 2'h1;
   localparam logic [1:0] CMD_COLD   = 2'h2;
   // Times in their own units
   localparam int unsigned HOLD_FILTER_US     = 100;
   localparam int unsigned INPUT_FILTER_MS    = 30;
   localparam int unsigned KEY_FILTER_MS      = 30;
   localparam int unsigned LONG_PRESS_S       = 16;
   localparam int unsigned HOLD_WAIT_MS       = 100;
   localparam int unsigned SEQ_STEP_US        = 10;
   // Slow tick of 1 us drives all long timers
   localparam int unsigned TICK_CYCLES        = CLK_MHZ;
   localparam int unsigned HOLD_FILTER_TICKS  = HOLD_FILTER_US;
   localparam int unsigned INPUT_FILTER_TICKS = INPUT_FILTER_MS * 1000;
   localparam int unsigned KEY_FILTER_TICKS   = KEY_FILTER_MS * 1000;
   localparam int unsigned LONG_PRESS_TICKS   = LONG_PRESS_S * 1000000;
   localparam int unsigned HOLD_WAIT_TICKS    = HOLD_WAIT_MS * 1000;
   localparam int unsigned SEQ_STEP_TICKS     = SEQ_STEP_US;
   localparam int unsigned NUM_RAILS          = 4;

   // Power sequencing states
   typedef enum logic [2:0] {
      PDIO_STANDBY = 3'b000,
      PDIO_UP      = 3'b001,
      PDIO_WAIT    = 3'b010,
      PDIO_ON      = 3'b011,
      PDIO_RSTDN   = 3'b100,
      PDIO_DOWN    = 3'b101
   } pdio_state_type;

   // Pad pair for open-drain or push-pull pins
   typedef struct packed {
      logic out;
      logic oe_n;
   } pdio_pad_type;
endpackage

// *** src/pdio_top.sv ***
/*
 Digital I/O of the power controller: onkey, interrupt output, reset
 output sequencing, power hold filter, and general pin, behind APB.
 Assumes pins arrive asynchronous to pclk and external pull-ups on the
 open-drain outputs; rails are enabled one per sequence step.
*/
module pdio_top
   import pdio_pkg::*;
#(
   parameter int unsigned LONG_PRESS_T  = LONG_PRESS_TICKS,   // Long press, in us ticks
   parameter int unsigned HOLD_WAIT_T   = HOLD_WAIT_TICKS,    // Hold wait, in us ticks
   parameter int unsigned PIN_FILTER_T  = INPUT_FILTER_TICKS, // Pin debounce, in us ticks
   parameter int unsigned KEY_FILTER_T  = KEY_FILTER_TICKS    // Key debounce, in us ticks
) (
   input  wire logic                 pclk,                // 200 MHz clock
   input  wire logic                 presetn,             // Async reset, low
   input  wire logic                 psel,                // APB select
   input  wire logic                 penable,             // APB enable
   input  wire logic                 pwrite,              // APB write
   input  wire logic [7:0]           paddr,               // APB byte address
   input  wire logic [31:0]          pwdata,              // APB write data
   output logic      [31:0]          prdata,              // APB read data
   output logic                      pready,              // APB ready
   output logic                      pslverr,             // APB error
   input  wire logic                 onkey_n,             // Onkey pin
   input  wire logic                 power_hold_in,       // Power hold pin
   input  wire logic                 charge_input_valid,  // Charger wakeup
   input  wire logic                 gpio_in,             // General pin level
   output logic                      gpio_out,            // General pin drive
   output logic                      gpio_oe_n,           // General pin enable, low
   output logic                      irq_out_out,         // Interrupt pin drive
   output logic                      irq_out_oe_n,        // Interrupt pin enable, low
   output logic                      reset_out_out,       // Reset pin drive
   output logic                      reset_out_oe_n,      // Reset pin enable, low
   output logic      [NUM_RAILS-1:0] rail_en,             // Regulator enables
   output logic                      power_hold_combined, // Hold to top control
   output logic                      filter_osc_en        // Debounce oscillator run
);

   // Pin synchronisers, first stage read only by second
   logic [3:0] sync1_q, sync2_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 4'h9;
         sync2_q <= 4'h9;
      end else begin
         sync1_q <= {onkey_n, power_hold_in, charge_input_valid, gpio_in};
         sync2_q <= sync1_q;
      end
   end
   wire key_s = sync2_q[3];
   wire hold_s = sync2_q[2];
   wire chg_s = sync2_q[1];
   wire pin_s = sync2_q[0];

   // Microsecond tick, gated so it runs only when a timer counts
   logic [7:0] tick_cnt_q;
   logic       tick;
   logic       timers_busy;
   assign tick = timers_busy && (tick_cnt_q == 8'(TICK_CYCLES - 1));
   assign filter_osc_en = timers_busy;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tick_cnt_q <= 8'h00;
      else if (!timers_busy || tick)
         tick_cnt_q <= 8'h00;
      else
         tick_cnt_q <= tick_cnt_q + 8'h01;
   end

   // Registers
   logic [4:0]          cfg_q;
   logic [IRQ_BITS-1:0] mask_q, flag_q, flag_set;
   logic                cmd_off_q;
   wire setup = psel && !penable;
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire hit_cfg = paddr == PDIO_CFG_ADDR;
   wire hit_mask = paddr == PDIO_MASK_ADDR;
   wire hit_flag = paddr == PDIO_FLAG_ADDR;
   wire hit_stat = paddr == PDIO_STATUS_ADDR;
   wire hit_cmd = paddr == PDIO_CMD_ADDR;
   wire mapped = hit_cfg | hit_mask | hit_flag | hit_stat | hit_cmd;
   wire [IRQ_BITS-1:0] flag_clr = (wr && hit_flag) ? pwdata[IRQ_BITS-1:0] : '0;
   wire cmd_wr = wr && hit_cmd &&
                 (pwdata[1:0] == CMD_OFF || pwdata[1:0] == CMD_COLD);
   assign pready = 1'b1;
   assign pslverr = acc && !mapped;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q  <= CFG_RESET;
         mask_q <= MASK_RESET;
      end else begin
         if (wr && hit_cfg)
            cfg_q <= pwdata[4:0];
         if (wr && hit_mask)
            mask_q <= pwdata[IRQ_BITS-1:0];
      end
   end

   // Sticky flags: set wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         flag_q <= '0;
      else
         flag_q <= (flag_q & ~flag_clr) | flag_set;
   end

   // Interrupt output is open-drain: pull low when any unmasked flag
   wire irq_any = |(flag_q & ~mask_q);
   assign irq_out_out = 1'b0;
   assign irq_out_oe_n = !irq_any;

   // Power hold glitch filter on the us tick
   logic       hold_f_q;
   logic [6:0] hold_cnt_q;
   wire hold_busy = hold_s != hold_f_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_f_q   <= 1'b0;
         hold_cnt_q <= 7'h00;
      end else if (!hold_busy) begin
         hold_cnt_q <= 7'h00;
      end else if (tick) begin
         if (hold_cnt_q == 7'(HOLD_FILTER_TICKS - 1)) begin
            hold_f_q   <= hold_s;
            hold_cnt_q <= 7'h00;
         end else begin
            hold_cnt_q <= hold_cnt_q + 7'h01;
         end
      end
   end
   assign power_hold_combined = hold_f_q | chg_s;

   // Onkey and pin debouncers, both 30 ms style
   logic        key_f_q, pin_f_q;
   logic [14:0] key_cnt_q, pin_cnt_q;
   wire key_busy = key_s != key_f_q;
   wire pin_busy = cfg_q[CFG_FILTER_ON] && (pin_s != pin_f_q);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_f_q   <= 1'b1;
         key_cnt_q <= 15'h0000;
      end else if (!key_busy) begin
         key_cnt_q <= 15'h0000;
      end else if (tick) begin
         if (key_cnt_q == 15'(KEY_FILTER_T - 1)) begin
            key_f_q   <= key_s;
            key_cnt_q <= 15'h0000;
         end else begin
            key_cnt_q <= key_cnt_q + 15'h0001;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_f_q   <= 1'b1;
         pin_cnt_q <= 15'h0000;
      end else if (!cfg_q[CFG_FILTER_ON]) begin
         pin_f_q   <= pin_s;
         pin_cnt_q <= 15'h0000;
      end else if (!pin_busy) begin
         pin_cnt_q <= 15'h0000;
      end else if (tick) begin
         if (pin_cnt_q == 15'(PIN_FILTER_T - 1)) begin
            pin_f_q   <= pin_s;
            pin_cnt_q <= 15'h0000;
         end else begin
            pin_cnt_q <= pin_cnt_q + 15'h0001;
         end
      end
   end

   // Edge events from the filtered levels
   logic key_d1_q, pin_d1_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_d1_q <= 1'b1;
         pin_d1_q <= 1'b1;
      end else begin
         key_d1_q <= key_f_q;
         pin_d1_q <= pin_f_q;
      end
   end
   wire key_fall = key_d1_q && !key_f_q;
   always_comb begin
      flag_set = '0;
      flag_set[IRQ_PIN_RISE] = !pin_d1_q && pin_f_q;
      flag_set[IRQ_PIN_FALL] = pin_d1_q && !pin_f_q;
      flag_set[IRQ_KEY_FALL] = key_fall;
      flag_set[IRQ_KEY_RISE] = !key_d1_q && key_f_q;
   end

   // General pin drive; input path always live
   wire pin_is_out = !cfg_q[CFG_DIR];
   wire pin_level = cfg_q[CFG_OUT_LEVEL];
   assign gpio_out = cfg_q[CFG_DRIVE_STYLE] ? pin_level : 1'b0;
   assign gpio_oe_n = !pin_is_out || (!cfg_q[CFG_DRIVE_STYLE] && pin_level);

   // Sequencer state and long timers
   pdio_state_type state_q, state_d;
   logic [23:0]    tmr_q;
   logic [2:0]     rail_idx_q;
   logic           cmd_pend;
   wire long_press = cfg_q[CFG_SWITCH_STYLE] ? key_f_q : !key_f_q;
   wire step_done = tick && tmr_q == 24'(SEQ_STEP_TICKS - 1);
   // Step wrap only in stepping states, else it would cut the long timers short
   wire in_step = state_q == PDIO_UP || state_q == PDIO_RSTDN || state_q == PDIO_DOWN;
   wire wait_done = tick && tmr_q == 24'(HOLD_WAIT_T - 1);
   wire press_done = tick && tmr_q == 24'(LONG_PRESS_T - 1);
   wire last_rail = rail_idx_q == 3'(NUM_RAILS);
   wire first_rail = rail_idx_q == 3'h0;
   wire go_down = !power_hold_combined || cmd_pend;
   assign cmd_pend = cmd_off_q;

   // Timers run in every state that counts toward something
   assign timers_busy = hold_busy || key_busy || pin_busy ||
                        state_q == PDIO_UP || state_q == PDIO_WAIT ||
                        state_q == PDIO_DOWN || state_q == PDIO_RSTDN ||
                        (state_q == PDIO_ON && long_press);

   always_comb begin
      state_d = state_q;
      case (state_q)
         PDIO_STANDBY: if (key_fall) state_d = PDIO_UP;
         PDIO_UP:      if (last_rail) state_d = PDIO_WAIT;
         PDIO_WAIT: begin
            if (cmd_pend)
               state_d = PDIO_RSTDN;
            else if (power_hold_combined)
               state_d = PDIO_ON;
            else if (wait_done)
               state_d = PDIO_RSTDN;
         end
         PDIO_ON: begin
            if (go_down || press_done)
               state_d = PDIO_RSTDN;
         end
         PDIO_RSTDN:   if (step_done) state_d = PDIO_DOWN;
         PDIO_DOWN:    if (first_rail) state_d = PDIO_STANDBY;
         default:      state_d = PDIO_STANDBY;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= PDIO_STANDBY;
         tmr_q      <= 24'h000000;
         rail_idx_q <= 3'h0;
         cmd_off_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         if (cmd_wr)
            cmd_off_q <= 1'b1;
         else if (state_q == PDIO_STANDBY)
            cmd_off_q <= 1'b0;
         if (state_d != state_q || (state_q == PDIO_ON && !long_press) ||
             (step_done && in_step))
            tmr_q <= 24'h000000;
         else if (tick)
            tmr_q <= tmr_q + 24'h000001;
         if (state_q == PDIO_UP && step_done && !last_rail)
            rail_idx_q <= rail_idx_q + 3'h1;
         else if (state_q == PDIO_DOWN && step_done && !first_rail)
            rail_idx_q <= rail_idx_q - 3'h1;
      end
   end

   // Rail enables: thermometer of the rail count
   genvar g;
   generate
      for (g = 0; g < NUM_RAILS; g++) begin : g_rail
         assign rail_en[g] = rail_idx_q > 3'(g);
      end
   endgenerate

   // Reset output held low outside the fully-up states
   wire rst_release = state_q == PDIO_WAIT || state_q == PDIO_ON;
   assign reset_out_out = 1'b0;
   assign reset_out_oe_n = rst_release;

   // Read mux, data zero for an unmapped address; prdata loaded in the setup phase of a read and held
   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h00000000;
      if (hit_cfg)
         rdata[4:0] = cfg_q;
      else if (hit_mask)
         rdata[IRQ_BITS-1:0] = mask_q;
      else if (hit_flag)
         rdata[IRQ_BITS-1:0] = flag_q;
      else if (hit_stat) begin
         rdata[ST_PIN_LEVEL] = pin_s;
         rdata[ST_KEY_LEVEL] = key_f_q;
         rdata[ST_ON] = rst_release;
         rdata[ST_HOLD] = power_hold_combined;
         rdata[ST_STATE_LSB+2:ST_STATE_LSB] = state_q;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (setup && !pwrite)
         prdata <= rdata;
   end

endmodule

// *** verif/pdio_props.sv ***
/*
 Checker for the digital I/O block: port-level timing relations.
 Assumes it is bound to pdio_top and sees only that module's ports.
*/
module pdio_props
   import pdio_pkg::*;
(
   input wire logic                 pclk,                // Clock
   input wire logic                 presetn,             // Reset, low
   input wire logic                 psel,                // APB select
   input wire logic                 penable,             // APB enable
   input wire logic                 pwrite,              // APB write
   input wire logic [7:0]           paddr,               // APB address
   input wire logic [31:0]          pwdata,              // APB write data
   input wire logic                 pslverr,             // APB error
   input wire logic                 power_hold_in,       // Hold pin
   input wire logic                 charge_input_valid,  // Charger wakeup
   input wire logic                 gpio_out,            // Pin drive
   input wire logic                 gpio_oe_n,           // Pin enable, low
   input wire logic                 irq_out_out,         // Interrupt drive
   input wire logic                 irq_out_oe_n,        // Interrupt enable, low
   input wire logic                 reset_out_oe_n,      // Reset enable, low
   input wire logic [NUM_RAILS-1:0] rail_en,             // Rail enables
   input wire logic                 power_hold_combined  // Combined hold
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] hold_cnt_q;
   // Length of the present high run of the hold pin, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) hold_cnt_q <= 16'h0000;
      else if (!power_hold_in) hold_cnt_q <= 16'h0000;
      else if (hold_cnt_q != 16'hffff) hold_cnt_q <= hold_cnt_q + 16'h0001;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_cfg_wr;
      s_access ##0 (pwrite && paddr == PDIO_CFG_ADDR);
   endsequence
   a_rst_rails: assert property (rail_en != 4'hf |-> !reset_out_oe_n)
      else $error("reset released with rails off");
   a_rst_first: assert property (|($past(rail_en) & ~rail_en) |->
      !reset_out_oe_n && !$past(reset_out_oe_n)) else $error("rail off before reset");
   a_irq_low: assert property (irq_out_out == 1'b0)
      else $error("interrupt pin driven high");
   a_mask_all: assert property (s_access ##0 (pwrite && paddr == PDIO_MASK_ADDR &&
      pwdata[3:0] == 4'hf) |=> irq_out_oe_n) else $error("masked flag drives irq");
   a_hold_glitch: assert property ($rose(power_hold_combined) && !charge_input_valid &&
      !$past(charge_input_valid, 3) |-> hold_cnt_q > 16'd19000) else $error("hold glitch");
   a_charger_hold: assert property (charge_input_valid [*4] |-> power_hold_combined)
      else $error("charger not holding");
   a_pin_input: assert property (s_cfg_wr ##0 pwdata[1] |=> gpio_oe_n)
      else $error("input pin driven");
   a_push_pull: assert property (s_cfg_wr ##0 pwdata[2:1] == 2'b10 |=>
      !gpio_oe_n && gpio_out == $past(pwdata[4])) else $error("push-pull wrong");
   a_bus_error: assert property (s_access ##0 paddr > PDIO_CMD_ADDR |-> pslverr)
      else $error("unmapped access accepted");
endmodule

bind pdio_top pdio_props u_pdio_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
   .power_hold_in(power_hold_in), .charge_input_valid(charge_input_valid),
   .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .irq_out_out(irq_out_out),
   .irq_out_oe_n(irq_out_oe_n), .reset_out_oe_n(reset_out_oe_n), .rail_en(rail_en),
   .power_hold_combined(power_hold_combined));

// *** verif/pdio_host_model.sv ***
/*
 Host processor model: power hold line and far side of the general pin.
 Assumes a pull-up on the pin, so a released pin shows the host level.
*/
module pdio_host_model (
   input  wire logic pclk,           // Clock
   input  wire logic presetn,        // Reset, low
   input  wire logic hold_en,        // Host wants power
   input  wire logic pin_drv,        // Host side pin level
   input  wire logic reset_out_oe_n, // Reset enable, low
   input  wire logic gpio_out,       // Pin drive
   input  wire logic gpio_oe_n,      // Pin enable, low
   output logic      power_hold_in,  // Hold line
   output logic      gpio_in         // Resolved pin level
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pin wire: device drive wins, else host level or pull-up
   assign gpio_in = gpio_oe_n ? pin_drv : gpio_out;
   // Hold follows the processor leaving reset; dropping it asks for power off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) power_hold_in <= 1'b0;
      else power_hold_in <= hold_en && reset_out_oe_n;
   end
endmodule

// *** verif/test_pdio_top.sv ***
/*
 Self-checking bench for the digital I/O block over APB.
 Assumes shortened timer parameters; one tick is 200 clocks.
*/
module test_pdio_top
   import pdio_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, onkey_n, charge_input_valid;
   logic power_hold_in, gpio_in, gpio_out, gpio_oe_n, irq_out_out, irq_out_oe_n;
   logic reset_out_out, reset_out_oe_n, power_hold_combined, filter_osc_en, pin_drv;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  rail_en;
   logic        e;
   int          fails, n_tests, n;
   logic [7:0]  cfgs [5] = '{8'h14, 8'h04, 8'h00, 8'h10, 8'h12};
   logic        oes  [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
   pdio_top #(.LONG_PRESS_T(20), .HOLD_WAIT_T(150), .PIN_FILTER_T(5), .KEY_FILTER_T(5))
   u_pdio_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .onkey_n(onkey_n), .power_hold_in(power_hold_in),
      .charge_input_valid(charge_input_valid), .gpio_in(gpio_in), .gpio_out(gpio_out),
      .gpio_oe_n(gpio_oe_n), .irq_out_out(irq_out_out), .irq_out_oe_n(irq_out_oe_n),
      .reset_out_out(reset_out_out), .reset_out_oe_n(reset_out_oe_n), .rail_en(rail_en),
      .power_hold_combined(power_hold_combined), .filter_osc_en(filter_osc_en));
   pdio_host_model u_pdio_host_model (.pclk(pclk), .presetn(presetn), .hold_en(1'b1),
      .pin_drv(pin_drv), .reset_out_oe_n(reset_out_oe_n), .gpio_out(gpio_out),
      .gpio_oe_n(gpio_oe_n), .power_hold_in(power_hold_in), .gpio_in(gpio_in));
   // Clock, 5 ns period
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic complete_run;
      $display("tests %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask
   // One APB transfer; held until pready is seen high at an edge, at most 50 edges
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      q = prdata; e = pslverr; psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic t_reset;
      apb(0, PDIO_CFG_ADDR, 0);  chk("cfg", 32'(CFG_RESET), q);
      apb(0, PDIO_MASK_ADDR, 0); chk("mask", 32'(MASK_RESET), q);
      chk("irq_oe_n", 1, irq_out_oe_n);
      chk("rst_oe_n", 0, reset_out_oe_n);
      apb(0, 8'h20, 0); chk("err", 1, e); chk("err_data", 0, q);
      apb(1, PDIO_CFG_ADDR, 32'h03);
      apb(0, PDIO_CFG_ADDR, 0); chk("slide_style", 32'h03, q);
      charge_input_valid <= 1'b1;
      repeat (6) @(posedge pclk);
      chk("hold2", 1, power_hold_combined);
      charge_input_valid <= 1'b0;
      $display("test reset done");
   endtask
   task automatic t_gpio;
      for (int i = 0; i < 5; i++) begin
         apb(1, PDIO_CFG_ADDR, 32'(cfgs[i]));
         @(negedge pclk);
         chk("gpio_oe_n", 32'(oes[i]), gpio_oe_n);
         // Let the new pin level cross the two-stage synchroniser
         repeat (3) @(posedge pclk);
         apb(0, PDIO_STATUS_ADDR, 0); chk("pin_level", gpio_in, q[0]);
      end
      $display("test gpio done");
   endtask
   task automatic t_irq;
      apb(1, PDIO_MASK_ADDR, 32'h0e);
      pin_drv <= 1'b0;
      repeat (5) @(posedge pclk);
      apb(1, PDIO_FLAG_ADDR, 32'h0f);
      @(negedge pclk);
      chk("irq_masked", 1, irq_out_oe_n);
      @(posedge pclk);
      pin_drv <= 1'b1;
      repeat (5) @(posedge pclk);
      @(negedge pclk);
      chk("irq_rise", 0, irq_out_oe_n);
      apb(0, PDIO_FLAG_ADDR, 0); chk("flags", 1, q[3:0]);
      apb(1, PDIO_FLAG_ADDR, 32'h01);
      @(negedge pclk);
      chk("irq_clear", 1, irq_out_oe_n);
      apb(1, PDIO_MASK_ADDR, 32'h0f);
      $display("test irq done");
   endtask
   task automatic t_filter;
      apb(1, PDIO_CFG_ADDR, 32'h0a);
      apb(1, PDIO_FLAG_ADDR, 32'h0f);
      pin_drv <= 1'b0;
      repeat (100) @(posedge pclk);
      chk("osc_run", 1, filter_osc_en);
      apb(0, PDIO_FLAG_ADDR, 0); chk("early_fall", 0, q[1]);
      repeat (1200) @(posedge pclk);
      chk("osc_stop", 0, filter_osc_en);
      apb(0, PDIO_FLAG_ADDR, 0); chk("late_fall", 1, q[1]);
      $display("test filter done");
   endtask
   task automatic t_power;
      onkey_n <= 1'b0;
      repeat (1500) @(posedge pclk);
      onkey_n <= 1'b1;
      n = 0;
      while (reset_out_oe_n !== 1'b1 && n < 40000) begin
         @(posedge pclk);
         n++;
      end
      chk("rails_up", 4'hf, rail_en);
      n = 0;
      while (power_hold_combined !== 1'b1 && n < 25000) begin
         @(posedge pclk);
         n++;
      end
      repeat (10) @(posedge pclk);
      apb(0, PDIO_STATUS_ADDR, 0); chk("on", 1, q[ST_ON]);
      apb(1, PDIO_CMD_ADDR, 32'(CMD_OFF));
      n = 0;
      while (rail_en !== 4'h0 && n < 20000) begin
         @(posedge pclk);
         n++;
      end
      chk("rails_down", 0, rail_en);
      chk("rst_down", 0, reset_out_oe_n);
      $display("test power done");
   endtask
   // Watchdog cuts a hang short
   initial begin
      repeat (90000) @(posedge pclk);
      fails++;
      complete_run;
   end
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; onkey_n = 1'b1; charge_input_valid = 1'b0; pin_drv = 1'b1;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_gpio;
      t_irq;
      t_filter;
      t_power;
      complete_run;
   end
endmodule
